//--- include/srw_params.svh
// Purpose: timing constants for the supervisory reset and watchdog block
// Assumes: oscillator tick counts; 10 MHz system clock
// Notes: definitions only
`ifndef SRW_PARAMS_SVH
`define SRW_PARAMS_SVH
`define SRW_CLK_HZ          10000000
`define SRW_RST_SHORT_MS    50
`define SRW_RST_LONG_MS     200
`define SRW_WD_FAST_MS      100
`define SRW_WD_SLOW_MS      1600
`define SRW_WD_POST_MS      1600
`define SRW_TICK_HZ         1000
`define SRW_TICK_DIV        (`SRW_CLK_HZ / `SRW_TICK_HZ)
`define SRW_CNT_W           12
`define SRW_EXP_RST         1'b1
`define SRW_RSTB_RST        1'b0
`endif

//--- include/srw_pkg.sv
// Purpose: types for the supervisory reset and watchdog block
// Assumes: nothing
// Notes: kick input level encoding
package srw_pkg;
    typedef enum logic [1:0] {SRW_KICK_LOW, SRW_KICK_MID, SRW_KICK_HIGH} srw_kick_t;
    typedef enum {SRW_RUN, SRW_HOLD} srw_state_t;
endpackage

//--- include/srw_tick_if.sv
// Purpose: oscillator tick carrier between timebase and main logic
// Assumes: single clock
// Notes: tick is a one-cycle pulse from the internal divider; an external tick passes as driven
`timescale 1ns/1ps
`default_nettype none
interface srw_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface
`default_nettype wire

//--- verilog/srw_timebase.sv
// Purpose: divides the system clock to oscillator ticks, or passes an external tick through
// Assumes: ext tick input synchronous
// Notes: external oscillator selected when osc_internal_in low
`timescale 1ns/1ps
`default_nettype none
`include "srw_params.svh"
module srw_timebase #(
    parameter int DIV = `SRW_TICK_DIV
) (
    input  wire logic mclk_in,
    input  wire logic rst_b_in,
    input  wire logic osc_internal_in,
    input  wire logic ext_tick_in,
    srw_tick_if.src   tk
);
    logic [23:0] div_ff;
    logic        tick_ff;
    if (DIV < 2 || DIV > (1 << 24))
    begin : g_bad_div
        $error("divider out of range");
    end
    // external ticks pass on every cycle; the divider only paces the internal source
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            div_ff  <= 24'h00_0000;
            tick_ff <= 1'b0;
        end
        else if (!osc_internal_in)
        begin
            div_ff  <= 24'h00_0000;
            tick_ff <= ext_tick_in;
        end
        else if (div_ff == 24'(DIV - 1))
        begin
            div_ff  <= 24'h00_0000;
            tick_ff <= 1'b1;
        end
        else
        begin
            div_ff  <= div_ff + 24'h00_0001;
            tick_ff <= 1'b0;
        end
    end
    assign tk.tick = tick_ff;
endmodule // srw_timebase
`default_nettype wire

//--- verilog/srw_supervisor.sv
// Purpose: reset, watchdog, power-fail and chip-enable gating logic
// Assumes: comparator results arrive as synchronous digital levels
// Notes: periods counted in 1 ms oscillator ticks
// Contract
// - reset low while supply below threshold or watchdog unserviced
// - hold reset low 50 ms (200 ms long variant) after supply recovers
// - watchdog expiry gives a 50 or 200 ms reset pulse
// - static kick beyond timeout pulses reset and drops expired output
// - every kick transition restarts the watchdog count
// - mid-level kick input disables the watchdog entirely
// - power-fail flag low while sense input below 1.3 V
// - supply below battery forces power-fail flag low
// - gated chip enable follows input when supply good, else high
// - backup-active high while switched supply fed from battery
// - supply-low output follows threshold comparator one clock later
// - higher of main and battery selected; selection reported
// - reset pulse width adjustable through oscillator configuration
// - expired output returns high on next kick transition
// - after any reset use 1.6 s watchdog timeout
// - expired output forced high when supply-low goes low
`timescale 1ns/1ps
`default_nettype none
`include "srw_params.svh"
module srw_supervisor #(
    parameter int RST_TICKS   = `SRW_RST_SHORT_MS,
    parameter int LONG_TICKS  = `SRW_RST_LONG_MS,
    parameter int FAST_TICKS  = `SRW_WD_FAST_MS,
    parameter int SLOW_TICKS  = `SRW_WD_SLOW_MS,
    parameter int POST_TICKS  = `SRW_WD_POST_MS,
    parameter int TICK_DIV    = `SRW_TICK_DIV
) (
    input  wire logic         mclk_in,
    input  wire logic         rst_b_in,
    input  wire logic         supply_low_cmp_in,
    input  wire logic         batt_above_supply_in,
    input  wire logic         pf_sense_low_in,
    input  wire srw_pkg::srw_kick_t watchdog_kick_input_in,
    input  wire logic         chip_en_b_in,
    input  wire logic         long_reset_in,
    input  wire logic         wd_slow_in,
    input  wire logic         osc_internal_in,
    input  wire logic         ext_tick_in,
    output logic              reset_b_out,
    output logic              watchdog_expired_output_b_out,
    output logic              power_fail_flag_output_b_out,
    output logic              chip_en_b_out,
    output logic              backup_active_output_out,
    output logic              low_line_b_out,
    output logic              batt_select_out
);
    localparam int W = `SRW_CNT_W;
    // a zero limit would wrap the last-count compare, so it is refused
    if (LONG_TICKS >= (1 << W) || SLOW_TICKS >= (1 << W) || POST_TICKS >= (1 << W)
        || FAST_TICKS >= (1 << W) || RST_TICKS >= (1 << W) || RST_TICKS < 1
        || LONG_TICKS < 1 || FAST_TICKS < 1 || SLOW_TICKS < 1 || POST_TICKS < 1)
    begin : g_bad_ticks
        $error("tick counts do not fit counter");
    end

    // last count before a limit; shared by hold and watchdog counters
    function automatic logic srw_at_last(input logic [W-1:0] cnt, input logic [W-1:0] lim);
        return cnt >= lim - W'(1);
    endfunction

    srw_tick_if tk ();
    // an external oscillator rescales every period at once
    srw_timebase #(.DIV(TICK_DIV)) u_tb (
        .mclk_in         (mclk_in),
        .rst_b_in        (rst_b_in),
        .osc_internal_in (osc_internal_in),
        .ext_tick_in     (ext_tick_in),
        .tk              (tk)
    );

    srw_pkg::srw_kick_t kick_prev_ff;
    srw_pkg::srw_state_t st_ff;
    logic [W-1:0] hold_ff;
    logic [W-1:0] wd_ff;
    logic         post_ff;
    logic         kick_edge;
    logic         wd_on;
    logic [W-1:0] wd_lim;
    logic [W-1:0] rst_lim;
    logic         wd_fire;

    assign wd_on     = watchdog_kick_input_in != srw_pkg::SRW_KICK_MID;
    assign kick_edge = wd_on && watchdog_kick_input_in != kick_prev_ff;
    assign wd_lim    = post_ff ? W'(POST_TICKS) : (wd_slow_in ? W'(SLOW_TICKS) : W'(FAST_TICKS));
    assign rst_lim   = long_reset_in ? W'(LONG_TICKS) : W'(RST_TICKS);
    assign wd_fire   = st_ff == srw_pkg::SRW_RUN && wd_on && tk.tick
                       && srw_at_last(wd_ff, wd_lim);

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            kick_prev_ff <= srw_pkg::SRW_KICK_MID;
        else
            kick_prev_ff <= watchdog_kick_input_in;
    end

    // reset-hold counter, kept apart from the watchdog count
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            st_ff   <= srw_pkg::SRW_HOLD;
            hold_ff <= '0;
        end
        else
        begin
            case (st_ff)
                srw_pkg::SRW_RUN:
                begin
                    hold_ff <= '0;
                    if (supply_low_cmp_in || wd_fire)
                        st_ff <= srw_pkg::SRW_HOLD;
                end
                srw_pkg::SRW_HOLD:
                begin
                    if (supply_low_cmp_in)
                        hold_ff <= '0;
                    else if (tk.tick && srw_at_last(hold_ff, rst_lim))
                        st_ff <= srw_pkg::SRW_RUN;
                    else if (tk.tick)
                        hold_ff <= hold_ff + W'(1);
                end
                default: st_ff <= srw_pkg::SRW_HOLD;
            endcase
        end
    end

    // watchdog counter; restarts while reset held so it begins with post timeout
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            wd_ff   <= '0;
            post_ff <= 1'b1;
        end
        else if (st_ff == srw_pkg::SRW_HOLD)
        begin
            wd_ff   <= '0;
            post_ff <= 1'b1;
        end
        else if (kick_edge || !wd_on)
        begin
            wd_ff   <= '0;
            post_ff <= post_ff && !kick_edge;
        end
        else if (tk.tick && !wd_fire)
            wd_ff <= wd_ff + W'(1);
    end

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            reset_b_out <= `SRW_RSTB_RST;
        else
            reset_b_out <= !(supply_low_cmp_in || wd_fire || st_ff == srw_pkg::SRW_HOLD);
    end

    // expiry flag: fire outranks a same-cycle kick clear so no event is lost; supply-low clears over fire
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            watchdog_expired_output_b_out <= `SRW_EXP_RST;
        else if (supply_low_cmp_in || !wd_on)
            watchdog_expired_output_b_out <= 1'b1;
        else if (wd_fire)
            watchdog_expired_output_b_out <= 1'b0;
        else if (kick_edge)
            watchdog_expired_output_b_out <= 1'b1;
    end

    // comparators are pre-synchronised; one flop keeps outputs registered
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            power_fail_flag_output_b_out <= 1'b0;
            chip_en_b_out                <= 1'b1;
            backup_active_output_out     <= 1'b0;
            low_line_b_out               <= 1'b0;
            batt_select_out              <= 1'b0;
        end
        else
        begin
            power_fail_flag_output_b_out <= !(pf_sense_low_in || batt_above_supply_in);
            chip_en_b_out                <= supply_low_cmp_in | chip_en_b_in;
            backup_active_output_out     <= batt_above_supply_in;
            low_line_b_out               <= !supply_low_cmp_in;
            batt_select_out              <= batt_above_supply_in;
        end
    end

    // first edge after reset release still shows reset values, hence the past guard
    a_low_line_follow: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        $past(rst_b_in) |-> low_line_b_out == !$past(supply_low_cmp_in))
        else $error("low line lag");
    a_ce_gate: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        $past(supply_low_cmp_in) |-> chip_en_b_out)
        else $error("ce not gated");
    a_pf_forced: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        batt_above_supply_in |=> !power_fail_flag_output_b_out)
        else $error("pf not low");
    a_pf_sense: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        pf_sense_low_in |=> !power_fail_flag_output_b_out)
        else $error("pf high");
    a_batt_flag: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        $past(rst_b_in) |-> backup_active_output_out == $past(batt_above_supply_in)
        && batt_select_out == $past(batt_above_supply_in))
        else $error("batt mismatch");
    a_reset_low: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        supply_low_cmp_in |=> !reset_b_out)
        else $error("reset not low");
    a_exp_supply: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        supply_low_cmp_in |=> watchdog_expired_output_b_out)
        else $error("expired not high");
    a_wd_fire_rst: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        wd_fire && !supply_low_cmp_in |=> !reset_b_out && !watchdog_expired_output_b_out)
        else $error("fire lost");
    a_mid_quiet: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        watchdog_kick_input_in == srw_pkg::SRW_KICK_MID && st_ff == srw_pkg::SRW_RUN
        && !supply_low_cmp_in |=> reset_b_out && watchdog_expired_output_b_out)
        else $error("wd fired disabled");
    a_hold_post: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        st_ff == srw_pkg::SRW_HOLD |=> post_ff && wd_ff == '0)
        else $error("post lost");
endmodule // srw_supervisor
`default_nettype wire

//--- sim/srw_host_model.sv
// Purpose: host model driving the three-level watchdog kick
// Assumes: kick period of 8 clocks, well inside the shortened timeout
// Notes: idle host leaves the kick at mid level
`timescale 1ns/1ps
`default_nettype none
module srw_host_model (
    input  wire logic          mclk_in,
    input  wire logic          run_in,
    input  wire logic          stall_in,
    output srw_pkg::srw_kick_t kick_out
);
    logic [2:0]         cnt_ff  = 3'h0;
    srw_pkg::srw_kick_t kick_ff = srw_pkg::SRW_KICK_MID;
    assign kick_out = kick_ff;
    // stall holds a static level on purpose, to starve the watchdog
    always @(negedge mclk_in)
    begin
        cnt_ff <= cnt_ff + 3'h1;
        if (!run_in)
            kick_ff <= srw_pkg::SRW_KICK_MID;
        else if (!stall_in && cnt_ff == 3'h0)
            kick_ff <= (kick_ff == srw_pkg::SRW_KICK_HIGH) ? srw_pkg::SRW_KICK_LOW
                                                           : srw_pkg::SRW_KICK_HIGH;
    end
endmodule // srw_host_model
`default_nettype wire

//--- sim/test_supervisory_reset_watchdog.sv
// Purpose: self-checking bench for the supervisory reset block
// Assumes: shortened tick divider and periods
// Notes: both tick sources, fast and slow watchdog periods, mid-run reset
`timescale 1ns/1ps
`default_nettype none
module test_supervisory_reset_watchdog;
    localparam int TD = 4;
    localparam int RT = 3;
    localparam int LT = 6;
    localparam int FT = 5;
    localparam int ST = 7;
    localparam int PT = 8;
    logic mclk_in = 1'b0, rst_b_in = 1'b0, long_rst = 1'b0, run = 1'b0, stall = 1'b0;
    logic sup_low = 1'b0, batt_hi = 1'b0, pf_low = 1'b0, ce_b = 1'b1;
    logic slow = 1'b0, osc_int = 1'b1, ext_tk = 1'b0;
    logic rst_b, exp_b, pff_b, ce_out, bk, ll_b, bsel;
    srw_pkg::srw_kick_t kick;
    int error_cnt = 0;
    int tests_run = 0;
    int n;
    // {supply low, batt above, sense low, ce in, pfo, ce out, backup, low line, select}
    logic [8:0] rows [6] = '{9'h03A, 9'h012, 9'h042, 9'h087, 9'h118, 9'h1ED};

    srw_host_model srw_host_model_inst (.mclk_in(mclk_in), .run_in(run), .stall_in(stall),
        .kick_out(kick));
    srw_supervisor #(.RST_TICKS(RT), .LONG_TICKS(LT), .FAST_TICKS(FT), .SLOW_TICKS(ST),
        .POST_TICKS(PT), .TICK_DIV(TD)) srw_supervisor_inst (
        .mclk_in(mclk_in), .rst_b_in(rst_b_in), .supply_low_cmp_in(sup_low),
        .batt_above_supply_in(batt_hi), .pf_sense_low_in(pf_low),
        .watchdog_kick_input_in(kick), .chip_en_b_in(ce_b), .long_reset_in(long_rst),
        .wd_slow_in(slow), .osc_internal_in(osc_int), .ext_tick_in(ext_tk),
        .reset_b_out(rst_b), .watchdog_expired_output_b_out(exp_b),
        .power_fail_flag_output_b_out(pff_b), .chip_en_b_out(ce_out),
        .backup_active_output_out(bk), .low_line_b_out(ll_b), .batt_select_out(bsel));

    initial
    begin
        forever #50 mclk_in = ~mclk_in;
    end

    task finish_test;
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input logic got, input logic exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t output %b expected %b", $time, got, exp);
        end
    endtask

    task rng(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi)
        begin
            error_cnt++;
            $display("BAD %0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask

    // bounded wait on the reset output, counting clocks
    task wait_rst(input logic v);
        n = 0;
        while (rst_b !== v && n < 300)
        begin
            @(negedge mclk_in);
            n++;
        end
        if (n >= 300)
        begin
            error_cnt++;
            $display("BAD %0t reset wait timed out", $time);
            finish_test();
        end
    endtask

    task hold_len(input logic lg, input int tk, input int td);
        long_rst = lg;
        sup_low = 1'b1;
        repeat (3) @(negedge mclk_in);
        chk(rst_b, 1'b0);
        chk(exp_b, 1'b1);
        sup_low = 1'b0;
        wait_rst(1'b1);
        rng(n, (tk - 1) * td, (tk + 1) * td + 2);
    endtask

    initial
    begin
        repeat (3) @(negedge mclk_in);
        chk(rst_b, 1'b0);
        chk(pff_b, 1'b0);
        chk(ce_out, 1'b1);
        rst_b_in = 1'b1;
        foreach (rows[i])
        begin
            {sup_low, batt_hi, pf_low, ce_b} = rows[i][8:5];
            repeat (2) @(negedge mclk_in);
            chk(pff_b, rows[i][4]);
            chk(ce_out, rows[i][3]);
            chk(bk, rows[i][2]);
            chk(ll_b, rows[i][1]);
            chk(bsel, rows[i][0]);
        end
        {sup_low, batt_hi, pf_low, ce_b} = 4'h1;
        hold_len(1'b0, RT, TD);
        hold_len(1'b1, LT, TD);
        long_rst = 1'b0;
        run = 1'b1;
        repeat (20 * TD) @(negedge mclk_in);
        chk(rst_b, 1'b1);
        stall = 1'b1;
        wait_rst(1'b0);
        rng(n, (FT - 1) * TD - 8, (FT + 1) * TD + 2);
        chk(exp_b, 1'b0);
        wait_rst(1'b1);
        rng(n, (RT - 1) * TD, (RT + 1) * TD + 2);
        chk(exp_b, 1'b0);
        // static kick again: post-reset timeout, not the fast one
        wait_rst(1'b0);
        rng(n, (PT - 1) * TD, (PT + 1) * TD + 2);
        wait_rst(1'b1);
        stall = 1'b0;
        repeat (10) @(negedge mclk_in);
        chk(exp_b, 1'b1);
        // slow period selected: starve again, longer timeout expected
        slow = 1'b1;
        repeat (10) @(negedge mclk_in);
        stall = 1'b1;
        wait_rst(1'b0);
        rng(n, (ST - 1) * TD - 8, (ST + 1) * TD + 2);
        chk(exp_b, 1'b0);
        wait_rst(1'b1);
        stall = 1'b0;
        slow = 1'b0;
        repeat (10) @(negedge mclk_in);
        chk(exp_b, 1'b1);
        run = 1'b0;
        repeat (60) @(negedge mclk_in);
        chk(rst_b, 1'b1);
        chk(exp_b, 1'b1);
        // external tick held high: one tick per clock shortens the hold
        osc_int = 1'b0;
        ext_tk = 1'b1;
        hold_len(1'b0, RT, 1);
        // asynchronous reset in mid-run
        rst_b_in = 1'b0;
        @(negedge mclk_in);
        chk(rst_b, 1'b0);
        chk(exp_b, 1'b1);
        rst_b_in = 1'b1;
        wait_rst(1'b1);
        rng(n, RT - 1, RT + 3);
        finish_test();
    end
endmodule // test_supervisory_reset_watchdog
`default_nettype wire
